// >>> include/spt_pkg.sv
package spt_pkg;

    // Software control settings.
    typedef struct packed {
        logic [1:0] index_zeroing_select;
        logic encoder_enable;
    } spt_ctrl_t;

    // Interrupt events raised by the tracker.
    typedef struct packed {
        logic zeroed;
        logic back_wrap;
        logic fwd_wrap;
        logic index;
    } spt_events_t;

    // Write channel response state.
    typedef enum logic [1:0] {
        SPT_WR_IDLE = 2'b01,
        SPT_WR_RESP = 2'b10
    } spt_wr_state_t;

endpackage

// >>> include/spt_regs.svh
`ifndef SPT_REGS_SVH
`define SPT_REGS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define SPT_OFS_CTRL 8'h00
`define SPT_OFS_STATUS 8'h04
`define SPT_OFS_ANGLE 8'h08
`define SPT_OFS_REVS 8'h0C
`define SPT_OFS_IRQ_STATUS 8'h10
`define SPT_OFS_IRQ_MASK 8'h14

// Control register field positions.
`define SPT_CTRL_ENC_EN 0
`define SPT_CTRL_SEL_LO 1
`define SPT_CTRL_SEL_HI 2
`define SPT_CTRL_POS_RESET 3

// Status register field positions.
`define SPT_STATUS_INDEX_SEEN 0

// Interrupt event bit positions.
`define SPT_IRQ_INDEX 0
`define SPT_IRQ_FWD_WRAP 1
`define SPT_IRQ_BACK_WRAP 2
`define SPT_IRQ_ZEROED 3
`define SPT_IRQ_BITS 4

// Index zeroing selection codes and reset values.
`define SPT_SEL_ENABLE 2'h1
`define SPT_SEL_DISABLE 2'h2
`define SPT_RST_SEL 2'h1
`define SPT_RST_ENC_EN 1'h1
`define SPT_RST_MASK 4'h0

// Angle range: 32768 divisions per turn.
`define SPT_ANGLE_MAX 15'h7FFF
`define SPT_ANGLE_ZERO 15'h0000

// AXI response codes.
`define SPT_RESP_OKAY 2'h0
`define SPT_RESP_SLVERR 2'h2

`endif

// >>> logic/spt_shaft_position_tracker.sv
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "spt_regs.svh"
// Overview of operation
// - With index zeroing selected as enable, each index pulse sets the shaft angle to zero.
// - With index zeroing selected as disable, a software position reset sets the angle to zero.
// - Any change of the encoder enable setting sets the shaft angle to zero.
// - A signed revolution counter records the complete turns of the shaft.
// - The revolution counter rises by one when the angle wraps forward from 32767 to 0.
// - The revolution counter falls by one when the angle wraps backward from 0 to 32767.
// - The index seen flag is cleared to 0 at power-up.
// - The index seen flag becomes 1 only on an index pulse while index zeroing is enabled.
// - The index seen flag reports whether the shaft angle is referenced to true zero; later zeroing by an enable change or position reset leaves it set.
// - Until an index pulse arrives, the position at power-up serves as the zero reference.
// - The angle has 32768 divisions per turn and starts at zero on power-up.
module spt_shaft_position_tracker
    import spt_pkg::*;
#(
    parameter int REV_WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_index,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [14:0] shaft_angle,
    output logic signed [REV_WIDTH-1:0] revolution_count,
    output logic index_seen_flag,
    output logic angle_valid,
    output logic irq
);

    // Decodes a register offset; used by both the write and the read path.
    function automatic logic reg_mapped(input logic [7:0] addr);
        case (addr)
            `SPT_OFS_CTRL, `SPT_OFS_STATUS, `SPT_OFS_ANGLE,
            `SPT_OFS_REVS, `SPT_OFS_IRQ_STATUS, `SPT_OFS_IRQ_MASK: reg_mapped = 1'b1;
            default: reg_mapped = 1'b0;
        endcase
    endfunction

    logic [1:0] rst_sync;
    logic rst_n_int;
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic a_prev;
    logic b_prev;
    logic z_prev;
    logic step;
    logic step_up;
    logic z_rise;
    spt_ctrl_t ctrl;
    logic enc_en_prev;
    logic enc_change;
    logic pos_reset_cmd;
    logic zero_now;
    logic fwd_wrap;
    logic back_wrap;
    spt_events_t events;
    logic [`SPT_IRQ_BITS-1:0] irq_status;
    logic [`SPT_IRQ_BITS-1:0] irq_mask;
    spt_wr_state_t wr_state;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_do;
    logic rd_take;
    logic [31:0] next_rdata;

    // The external reset is released through two flip-flops.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n_int = rst_sync[1];

    // Encoder pins pass two flip-flops before any logic reads them.
    generate
        for (genvar i = 0; i < 3; i++) begin : g_pin_sync
            always_ff @(posedge clk or negedge rst_n_int) begin
                if (!rst_n_int) begin
                    pin_meta[i] <= 1'b0;
                    pin_sync[i] <= 1'b0;
                end else begin
                    pin_meta[i] <= (i == 0) ? enc_a : ((i == 1) ? enc_b : enc_index);
                    pin_sync[i] <= pin_meta[i];
                end
            end
        end
    endgenerate

    // Previous synchronised pin levels for edge and quadrature decoding.
    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            a_prev <= 1'b0;
            b_prev <= 1'b0;
            z_prev <= 1'b0;
        end else begin
            a_prev <= pin_sync[0];
            b_prev <= pin_sync[1];
            z_prev <= pin_sync[2];
        end
    end

    // Quadrature decode: one count when exactly one channel moved.
    assign step = ctrl.encoder_enable & ((pin_sync[0] ^ a_prev) ^ (pin_sync[1] ^ b_prev));
    assign step_up = pin_sync[0] ^ b_prev;
    assign z_rise = pin_sync[2] & ~z_prev;

    // Zeroing sources: index pulse, software command, or enable change.
    assign enc_change = ctrl.encoder_enable ^ enc_en_prev;
    assign zero_now = enc_change
        | (z_rise & (ctrl.index_zeroing_select == `SPT_SEL_ENABLE))
        | (pos_reset_cmd & (ctrl.index_zeroing_select == `SPT_SEL_DISABLE));
    assign fwd_wrap = step & step_up & ~zero_now & (shaft_angle == `SPT_ANGLE_MAX);
    assign back_wrap = step & ~step_up & ~zero_now & (shaft_angle == `SPT_ANGLE_ZERO);

    // Shaft angle: zero at power-up, which stands as reference until an index pulse.
    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            shaft_angle <= `SPT_ANGLE_ZERO;
        end else if (zero_now) begin
            shaft_angle <= `SPT_ANGLE_ZERO;
        end else if (step && step_up) begin
            shaft_angle <= shaft_angle + 15'h0001;
        end else if (step) begin
            shaft_angle <= shaft_angle - 15'h0001;
        end
    end

    // Signed count of complete turns, moved only by angle wraps.
    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            revolution_count <= '0;
        end else if (fwd_wrap) begin
            revolution_count <= revolution_count + REV_WIDTH'(1);
        end else if (back_wrap) begin
            revolution_count <= revolution_count - REV_WIDTH'(1);
        end
    end

    // Index seen flag, set when an index pulse zeroes the angle and kept through later zeroing.
    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            index_seen_flag <= 1'b0;
        end else if (z_rise && ctrl.index_zeroing_select == `SPT_SEL_ENABLE) begin
            index_seen_flag <= 1'b1;
        end
    end
    assign angle_valid = index_seen_flag;

    // Write channel: address and data are taken in either order.
    assign s_axi_awready = ~aw_held & (wr_state == SPT_WR_IDLE);
    assign s_axi_wready = ~w_held & (wr_state == SPT_WR_IDLE);
    assign wr_do = aw_held & w_held & (wr_state == SPT_WR_IDLE);
    assign s_axi_bvalid = (wr_state == SPT_WR_RESP);

    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            wr_state <= SPT_WR_IDLE;
            s_axi_bresp <= `SPT_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            case (wr_state)
                SPT_WR_IDLE: begin
                    if (wr_do) begin
                        aw_held <= 1'b0;
                        w_held <= 1'b0;
                        s_axi_bresp <= reg_mapped(aw_addr) ? `SPT_RESP_OKAY : `SPT_RESP_SLVERR;
                        wr_state <= SPT_WR_RESP;
                    end
                end
                SPT_WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state <= SPT_WR_IDLE;
                    end
                end
                default: begin
                    wr_state <= SPT_WR_IDLE;
                end
            endcase
        end
    end

    // Control and mask registers; the position reset bit is a one-cycle command.
    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            ctrl.encoder_enable <= `SPT_RST_ENC_EN;
            ctrl.index_zeroing_select <= `SPT_RST_SEL;
            enc_en_prev <= `SPT_RST_ENC_EN;
            pos_reset_cmd <= 1'b0;
            irq_mask <= `SPT_RST_MASK;
        end else begin
            enc_en_prev <= ctrl.encoder_enable;
            pos_reset_cmd <= 1'b0;
            if (wr_do && w_strb[0] && aw_addr == `SPT_OFS_CTRL) begin
                ctrl.encoder_enable <= w_data[`SPT_CTRL_ENC_EN];
                ctrl.index_zeroing_select <= w_data[`SPT_CTRL_SEL_HI:`SPT_CTRL_SEL_LO];
                pos_reset_cmd <= w_data[`SPT_CTRL_POS_RESET];
            end
            if (wr_do && w_strb[0] && aw_addr == `SPT_OFS_IRQ_MASK) begin
                irq_mask <= w_data[`SPT_IRQ_BITS-1:0];
            end
        end
    end

    // Read channel answers one cycle after the address is taken.
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_take = s_axi_arvalid & s_axi_arready;

    always_comb begin
        next_rdata = 32'h00000000;
        case (s_axi_araddr)
            `SPT_OFS_CTRL: next_rdata[`SPT_CTRL_SEL_HI:0] = ctrl;
            `SPT_OFS_STATUS: next_rdata[`SPT_STATUS_INDEX_SEEN] = index_seen_flag;
            `SPT_OFS_ANGLE: next_rdata[14:0] = shaft_angle;
            `SPT_OFS_REVS: next_rdata = 32'(revolution_count);
            `SPT_OFS_IRQ_STATUS: next_rdata[`SPT_IRQ_BITS-1:0] = irq_status;
            `SPT_OFS_IRQ_MASK: next_rdata[`SPT_IRQ_BITS-1:0] = irq_mask;
            default: next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SPT_RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= reg_mapped(s_axi_araddr) ? `SPT_RESP_OKAY : `SPT_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Sticky events; a read clears them, but a new event in that cycle survives.
    assign events.index = z_rise;
    assign events.fwd_wrap = fwd_wrap;
    assign events.back_wrap = back_wrap;
    assign events.zeroed = zero_now;

    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            irq_status <= '0;
        end else if (rd_take && s_axi_araddr == `SPT_OFS_IRQ_STATUS) begin
            irq_status <= events;
        end else begin
            irq_status <= irq_status | events;
        end
    end
    assign irq = |(irq_status & irq_mask);

    // Checks on the tracking behaviour.
    index_zero_a: assert property (@(posedge clk) disable iff (!rst_n_int)
        (z_rise && ctrl.index_zeroing_select == `SPT_SEL_ENABLE) |=> shaft_angle == 15'h0000)
        else $error("Index pulse did not zero the angle.");
    cmd_zero_a: assert property (@(posedge clk) disable iff (!rst_n_int)
        (pos_reset_cmd && ctrl.index_zeroing_select == `SPT_SEL_DISABLE)
        |=> shaft_angle == 15'h0000)
        else $error("Position reset did not zero the angle.");
    enable_zero_a: assert property (@(posedge clk) disable iff (!rst_n_int)
        (ctrl.encoder_enable != enc_en_prev) |=> shaft_angle == 15'h0000)
        else $error("Enable change did not zero the angle.");
    revs_hold_a: assert property (@(posedge clk) disable iff (!rst_n_int)
        !(fwd_wrap || back_wrap) |=> $stable(revolution_count))
        else $error("Revolution count moved without a wrap.");
    fwd_wrap_a: assert property (@(posedge clk) disable iff (!rst_n_int)
        (step && step_up && !zero_now && shaft_angle == 15'h7FFF)
        |=> shaft_angle == 15'h0000 && revolution_count == $past(revolution_count) + 1)
        else $error("Forward wrap not counted.");
    back_wrap_a: assert property (@(posedge clk) disable iff (!rst_n_int)
        (step && !step_up && !zero_now && shaft_angle == 15'h0000)
        |=> shaft_angle == 15'h7FFF && revolution_count == $past(revolution_count) - 1)
        else $error("Backward wrap not counted.");
    flag_cause_a: assert property (@(posedge clk) disable iff (!rst_n_int)
        $rose(index_seen_flag) |-> $past(z_rise && ctrl.index_zeroing_select == `SPT_SEL_ENABLE))
        else $error("Index seen flag rose without cause.");
    valid_flag_a: assert property (@(posedge clk) disable iff (!rst_n_int)
        $rose(angle_valid) |-> shaft_angle == `SPT_ANGLE_ZERO)
        else $error("Angle became valid away from zero.");
    step_move_a: assert property (@(posedge clk) disable iff (!rst_n_int)
        (step && step_up && !zero_now) |=> shaft_angle == $past(shaft_angle) + 15'h0001)
        else $error("Forward count did not advance the angle.");

endmodule

// >>> test/shaft_position_tracker_tb.sv
`timescale 1ns/100ps
`include "spt_regs.svh"
module shaft_position_tracker_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic up = 1'b0, dn = 1'b0, idx = 1'b0, en = 1'b1;
    logic enc_a, enc_b, enc_index, awready, wready, bvalid, arready, rvalid, flag, valid, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd, seed = 32'h41E5;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, rs;
    logic [14:0] angle, exp_ang = 15'h0;
    logic exp_flag = 1'b0;
    logic signed [31:0] revs, exp_revs = 32'sh0;
    int n_errors = 0, samples_checked = 0;
    spt_encoder_model enc (.clk(clk), .step_up(up), .step_dn(dn), .index_req(idx),
        .enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index));
    spt_shaft_position_tracker dut (.clk(clk), .rst_n(rst_n), .enc_a(enc_a), .enc_b(enc_b),
        .enc_index(enc_index), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .shaft_angle(angle), .revolution_count(revs), .index_seen_flag(flag),
        .angle_valid(valid), .irq(irq));
    // The clock runs at 10 MHz.
    initial begin
        forever #50 clk = ~clk;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Compares one value with its expectation.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // A wait that ran out of cycles ends the run.
    task automatic hang;
        n_errors++;
        $display("[FAIL] %0t bus timeout", $time);
        test_done();
    endtask
    // Readies are judged at the falling edge; releases follow the edge that took the item.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_hit, w_hit, b_hit, done;
        done = 1'b0;
        r = 2'h3;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(negedge clk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            b_hit = bvalid && bready;
            if (b_hit) r = bresp;
            @(posedge clk);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
            if (b_hit) bready <= 1'b0;
            done = b_hit;
        end
        if (!done) hang();
    endtask
    // Read address is held until taken, rready until the data arrives.
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ar_hit, r_hit, done;
        done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(negedge clk);
            ar_hit = arvalid && arready;
            r_hit = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar_hit) arvalid <= 1'b0;
            if (r_hit) rready <= 1'b0;
            done = r_hit;
        end
        if (!done) hang();
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        axi_rd(a, rd, rs);
        chk(rd, ed);
        chk({30'h0, rs}, {30'h0, er});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_wr(a, d, rs);
        chk({30'h0, rs}, {30'h0, `SPT_RESP_OKAY});
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Expected angle and turn count after one decoded step.
    function automatic void move(input bit fwd);
        if (fwd && exp_ang == `SPT_ANGLE_MAX) exp_revs = exp_revs + 32'sh1;
        if (!fwd && exp_ang == `SPT_ANGLE_ZERO) exp_revs = exp_revs - 32'sh1;
        exp_ang = fwd ? exp_ang + 15'h1 : exp_ang - 15'h1;
    endfunction
    // One encoder step, given time to pass the synchronisers.
    task automatic step(input bit fwd);
        @(posedge clk);
        up <= fwd;
        dn <= !fwd;
        @(posedge clk);
        up <= 1'b0;
        dn <= 1'b0;
        repeat (4) @(posedge clk);
        if (en) move(fwd);
    endtask
    task automatic look;
        @(negedge clk);
        chk({17'h0, angle}, {17'h0, exp_ang});
        chk(revs, exp_revs);
        chk({31'h0, valid}, {31'h0, exp_flag});
        chk({31'h0, flag}, {31'h0, exp_flag});
    endtask
    task automatic zpulse;
        @(posedge clk);
        idx <= 1'b1;
        repeat (3) @(posedge clk);
        idx <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    // Main sequence: corner cases first, a random walk, then the zeroing sources.
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        look();
        chk({31'h0, flag}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rd_chk(`SPT_OFS_CTRL, 32'h3, `SPT_RESP_OKAY);
        step(1'b0);
        look();
        step(1'b1);
        look();
        rd_chk(`SPT_OFS_IRQ_STATUS, 32'h6, `SPT_RESP_OKAY);
        rd_chk(`SPT_OFS_IRQ_STATUS, 32'h0, `SPT_RESP_OKAY);
        for (int i = 0; i < 60; i++) begin
            seed = xs(seed);
            step(seed[0]);
            look();
        end
        rd_chk(`SPT_OFS_ANGLE, {17'h0, exp_ang}, `SPT_RESP_OKAY);
        rd_chk(`SPT_OFS_REVS, exp_revs, `SPT_RESP_OKAY);
        rd_chk(8'h18, 32'h0, `SPT_RESP_SLVERR);
        wr(`SPT_OFS_ANGLE, 32'h1234);
        rd_chk(`SPT_OFS_ANGLE, {17'h0, exp_ang}, `SPT_RESP_OKAY);
        axi_rd(`SPT_OFS_IRQ_STATUS, rd, rs);
        wr(`SPT_OFS_IRQ_MASK, 32'h1);
        wr(`SPT_OFS_CTRL, 32'h5);
        step(1'b1);
        step(1'b1);
        zpulse();
        look();
        chk({31'h0, flag}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        // Two forward steps that end at 0 or 1 crossed the wrap and also set that event.
        rd_chk(`SPT_OFS_IRQ_STATUS, {30'h0, exp_ang < 15'h2, 1'b1}, `SPT_RESP_OKAY);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(`SPT_OFS_CTRL, 32'hD);
        repeat (4) @(posedge clk);
        exp_ang = `SPT_ANGLE_ZERO;
        look();
        step(1'b1);
        step(1'b1);
        wr(`SPT_OFS_CTRL, 32'h3);
        zpulse();
        exp_ang = `SPT_ANGLE_ZERO;
        exp_flag = 1'b1;
        look();
        chk({31'h0, flag}, 32'h1);
        rd_chk(`SPT_OFS_STATUS, 32'h1, `SPT_RESP_OKAY);
        step(1'b1);
        wr(`SPT_OFS_CTRL, 32'h2);
        en = 1'b0;
        repeat (4) @(posedge clk);
        exp_ang = `SPT_ANGLE_ZERO;
        look();
        step(1'b1);
        look();
        // Clear old events so that only the zeroing by the enable rise remains.
        axi_rd(`SPT_OFS_IRQ_STATUS, rd, rs);
        wr(`SPT_OFS_CTRL, 32'h3);
        en = 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(`SPT_OFS_IRQ_STATUS, 32'h8, `SPT_RESP_OKAY);
        step(1'b0);
        look();
        test_done();
    end
endmodule

// >>> test/spt_encoder_model.sv
`timescale 1ns/100ps
// Quadrature encoder on the shaft: one gray-code phase per step request, index on demand.
module spt_encoder_model (
    input wire logic clk,
    input wire logic step_up,
    input wire logic step_dn,
    input wire logic index_req,
    output logic enc_a,
    output logic enc_b,
    output logic enc_index
);
    logic [1:0] phase = 2'h0;
    // The phase moves forward on step_up and backward on step_dn, never both channels at once.
    always_ff @(posedge clk) begin
        if (step_up) begin
            phase <= phase + 2'h1;
        end else if (step_dn) begin
            phase <= phase - 2'h1;
        end
    end
    // Forward order of the channel pair is 00, 10, 11, 01.
    assign enc_a = phase[1] ^ phase[0];
    assign enc_b = phase[1];
    assign enc_index = index_req;
endmodule
